// File: src/msr_pkg.sv
package msr_pkg;
  // ****************************************
  // widths and address space
  // ****************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 6;
  // ****************************************
  // operation register offsets
  // ****************************************
  localparam logic [5:0] OFF_INDIRECT = 6'h00;
  localparam logic [5:0] OFF_TIMER = 6'h01;
  localparam logic [5:0] OFF_PC = 6'h02;
  localparam logic [5:0] OFF_STATUS = 6'h03;
  localparam logic [5:0] OFF_SELECT = 6'h04;
  localparam logic [5:0] OFF_PORT_FIRST = 6'h05;
  localparam logic [5:0] OFF_PORT_LAST = 6'h09;
  localparam logic [5:0] OFF_EEPROM = 6'h0A;
  localparam logic [5:0] OFF_MISC_B = 6'h0B;
  localparam logic [5:0] OFF_USB_EP = 6'h0C;
  localparam logic [5:0] OFF_FIFO_ADDR = 6'h0D;
  localparam logic [5:0] OFF_FIFO_DATA = 6'h0E;
  localparam logic [5:0] OFF_IRQ_FLAGS = 6'h0F;
  localparam logic [5:0] OFF_EXTRA_FIRST = 6'h0A;
  localparam logic [5:0] OFF_EXTRA_LAST = 6'h0E;
  // ****************************************
  // field positions
  // ****************************************
  localparam int EXTRA_SEL_BIT = 3;
  localparam int BANK_LO_BIT = 6;
  localparam int BANK_HI_BIT = 7;
  localparam int EE_DONE_BIT = 2;
  localparam int ADC_LOW_BITS = 2;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_EEPROM = 8'hFF;
  localparam logic [7:0] RST_MISC_B = 8'hFF;
  localparam logic [7:0] RST_MODE = 8'hC0;
  localparam logic [7:0] RST_P9_CFG_B = 8'h7F;
  localparam logic [7:0] RST_WAKE = 8'hD7;
  localparam logic [7:0] RST_ADC_CTRL = 8'h1F;
  localparam logic [7:0] RST_EXTRA_SCALE = 8'h01;
  localparam logic [7:0] RST_PRESCALE = 8'h3F;
  // ****************************************
  // access kinds
  // ****************************************
  typedef enum logic [2:0]
  {
    MSR_IDLE = 3'b001,
    MSR_OPER = 3'b010,
    MSR_CTRL = 3'b100
  } msr_access_type;
endpackage

// File: src/msr_bitop.sv
`timescale 1ns/1ps
// single-bit set, clear and test over one register value
module msr_bitop
(
  input wire logic [7:0] value_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic set_in,
  input wire logic clr_in,
  output logic [7:0] value_out,
  output logic bit_out
);
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_bit
      // only the selected bit moves; all others pass through untouched
      assign value_out[g] = (bit_sel_in == 3'(g)) ?
                            ((value_in[g] | set_in) & ~clr_in) : value_in[g];
    end
  endgenerate
  assign bit_out = value_in[bit_sel_in];
endmodule // msr_bitop

// File: src/msr_addr_resolve.sv
`timescale 1ns/1ps
// resolves the effective operation address, following the indirect port
module msr_addr_resolve
(
  input wire logic [5:0] addr_in,
  input wire logic [7:0] select_in,
  output logic [5:0] eff_addr_out,
  output logic [1:0] bank_out
);
  assign eff_addr_out = (addr_in == msr_pkg::OFF_INDIRECT) ? select_in[5:0] : addr_in;
  assign bank_out = select_in[msr_pkg::BANK_HI_BIT:msr_pkg::BANK_LO_BIT];
endmodule // msr_addr_resolve

// File: src/msr_register_map.sv
`timescale 1ns/1ps
// What this block does
// - offset 0x00 accesses register named by select
// - select bits 6-7 choose the bank
// - each port direction shares its data offset
// - mode bit 3 swaps 0x0A-0x0E to extra bank
// - 0x0B extra shows two low conversion bits
// - any writable bit settable, clearable, and any bit testable alone, except the prescaler's (written whole by prescale_wr_in only)
// - port registers act as ordinary registers
module msr_register_map
#(
  parameter int GP_DEPTH = 48,
  parameter int BANKS = 4
)
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [5:0] addr_in,
  input wire logic ctrl_space_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] wdata_in,
  input wire logic bit_set_in,
  input wire logic bit_clr_in,
  input wire logic bit_test_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic prescale_wr_in,
  input wire logic [9:0] adc_result_in,
  input wire logic eeprom_done_in,
  input wire logic [7:0] hw_irq_in,
  input wire logic [39:0] port_pins_in,
  output logic [7:0] rdata_out,
  output logic bit_out,
  output logic [39:0] port_data_out,
  output logic [39:0] port_dir_out,
  output logic [7:0] mode_out,
  output logic [7:0] irq_flags_out,
  output logic [7:0] irq_mask_out,
  output logic [7:0] eeprom_cmd_out,
  output logic eeprom_start_out,
  output logic [7:0] prescale_out
);
  // ****************************************
  // storage
  // ****************************************
  logic [7:0] oper_q [0:15];
  logic [7:0] ctrl_q [5:15];
  logic [7:0] extra_q [10:14];
  logic [7:0] gp_q [0:BANKS-1][0:GP_DEPTH-1];
  logic [7:0] prescale_q;
  logic [7:0] rdata_q;
  logic bit_q;
  logic eeprom_start_q;
  logic [5:0] eff_addr;
  logic [1:0] bank;
  logic extra_sel;
  logic is_extra;
  logic [7:0] cur_val;
  logic [7:0] new_val;
  logic cur_bit;
  logic any_wr;
  logic [7:0] wr_val;
  msr_pkg::msr_access_type acc;

  msr_addr_resolve u_resolve
  (
    .addr_in(addr_in),
    .select_in(oper_q[4]),
    .eff_addr_out(eff_addr),
    .bank_out(bank)
  );

  // ****************************************
  // access decode
  // ****************************************
  always_comb
  begin
    if (!(wr_in || rd_in || bit_set_in || bit_clr_in || bit_test_in))
      acc = msr_pkg::MSR_IDLE;
    else if (ctrl_space_in)
      acc = msr_pkg::MSR_CTRL;
    else
      acc = msr_pkg::MSR_OPER;
  end

  assign extra_sel = ctrl_q[10][msr_pkg::EXTRA_SEL_BIT];
  assign is_extra = extra_sel && (acc == msr_pkg::MSR_OPER) &&
                    (eff_addr >= msr_pkg::OFF_EXTRA_FIRST) &&
                    (eff_addr <= msr_pkg::OFF_EXTRA_LAST);

  // current value of the addressed register
  always_comb
  begin
    cur_val = msr_pkg::RST_ZERO;
    case (acc)
      msr_pkg::MSR_CTRL:
      begin
        if (addr_in >= 6'h05 && addr_in <= 6'h0F)
          cur_val = ctrl_q[addr_in[3:0]];
      end
      msr_pkg::MSR_OPER:
      begin
        if (is_extra)
        begin
          if (eff_addr == msr_pkg::OFF_MISC_B)
            cur_val = {6'h00, adc_result_in[msr_pkg::ADC_LOW_BITS-1:0]};
          else if (eff_addr == msr_pkg::OFF_USB_EP)
            cur_val = adc_result_in[9:2];
          else
            cur_val = extra_q[eff_addr[3:0]];
        end
        else if (eff_addr == msr_pkg::OFF_INDIRECT)
          cur_val = msr_pkg::RST_ZERO;
        else if (eff_addr < 6'h10)
          cur_val = oper_q[eff_addr[3:0]];
        else if (int'(eff_addr) - 16 < GP_DEPTH)
          cur_val = gp_q[bank][eff_addr - 6'h10];
      end
      default: cur_val = msr_pkg::RST_ZERO;
    endcase
  end

  msr_bitop u_bitop
  (
    .value_in(cur_val),
    .bit_sel_in(bit_sel_in),
    .set_in(bit_set_in),
    .clr_in(bit_clr_in),
    .value_out(new_val),
    .bit_out(cur_bit)
  );

  assign any_wr = wr_in || bit_set_in || bit_clr_in;
  assign wr_val = wr_in ? wdata_in : new_val;

  // ****************************************
  // operation registers
  // ****************************************
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < 16; i++)
        oper_q[i] <= msr_pkg::RST_ZERO;
      oper_q[3] <= msr_pkg::RST_STATUS;
      oper_q[10] <= msr_pkg::RST_EEPROM;
      oper_q[11] <= msr_pkg::RST_MISC_B;
    end
    else if (ce_in)
    begin
      // flags: hardware set wins over a software clear in the same cycle
      oper_q[15] <= oper_q[15] | hw_irq_in;
      oper_q[10][msr_pkg::EE_DONE_BIT] <= oper_q[10][msr_pkg::EE_DONE_BIT] | eeprom_done_in;
      if (any_wr && acc == msr_pkg::MSR_OPER && !is_extra && eff_addr < 6'h10 &&
          eff_addr != msr_pkg::OFF_INDIRECT)
      begin
        if (eff_addr == msr_pkg::OFF_IRQ_FLAGS)
          oper_q[15] <= wr_val | hw_irq_in;
        else if (eff_addr == msr_pkg::OFF_EEPROM)
          oper_q[10] <= wr_val | {5'h00, eeprom_done_in, 2'b00};
        else
          oper_q[eff_addr[3:0]] <= wr_val;
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      eeprom_start_q <= 1'b0;
    else if (ce_in)
      // command launch; spacing of commands is software's job
      eeprom_start_q <= wr_in && acc == msr_pkg::MSR_OPER && !is_extra &&
                        eff_addr == msr_pkg::OFF_EEPROM;
  end

  // ****************************************
  // general registers, banked
  // ****************************************
  always_ff @(posedge clk_sys_in)
  begin
    if (ce_in && any_wr && acc == msr_pkg::MSR_OPER && eff_addr >= 6'h10 &&
        int'(eff_addr) - 16 < GP_DEPTH)
      gp_q[bank][eff_addr - 6'h10] <= wr_val;
  end

  // ****************************************
  // control registers and extra bank
  // ****************************************
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      for (int i = 5; i < 16; i++)
        ctrl_q[i] <= msr_pkg::RST_ZERO;
      for (int i = 5; i < 10; i++)
        ctrl_q[i] <= msr_pkg::RST_DIR;
      ctrl_q[10] <= msr_pkg::RST_MODE;
      ctrl_q[11] <= msr_pkg::RST_P9_CFG_B;
      ctrl_q[14] <= msr_pkg::RST_WAKE;
    end
    else if (ce_in && any_wr && acc == msr_pkg::MSR_CTRL && addr_in >= 6'h05 &&
             addr_in <= 6'h0F)
      ctrl_q[addr_in[3:0]] <= wr_val;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      extra_q[10] <= msr_pkg::RST_ADC_CTRL;
      extra_q[11] <= msr_pkg::RST_ZERO;
      extra_q[12] <= msr_pkg::RST_ZERO;
      extra_q[13] <= msr_pkg::RST_ZERO;
      extra_q[14] <= msr_pkg::RST_EXTRA_SCALE;
    end
    else if (ce_in && any_wr && is_extra && eff_addr != msr_pkg::OFF_MISC_B &&
             eff_addr != msr_pkg::OFF_USB_EP)
      extra_q[eff_addr[3:0]] <= wr_val;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      prescale_q <= msr_pkg::RST_PRESCALE;
    else if (ce_in && prescale_wr_in)
      prescale_q <= wdata_in;
  end

  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      rdata_q <= msr_pkg::RST_ZERO;
      bit_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (rd_in)
        rdata_q <= cur_val;
      if (bit_test_in)
        bit_q <= cur_bit;
    end
  end

  // ****************************************
  // outputs, registered
  // ****************************************
  logic [39:0] pdata_q;
  logic [39:0] pdir_q;
  logic [7:0] mode_q;
  logic [7:0] flags_q;
  logic [7:0] mask_q;
  logic [7:0] ecmd_q;
  genvar p;
  generate
    for (p = 0; p < 5; p++)
    begin : g_port
      always_ff @(posedge clk_sys_in)
      begin
        if (rst_in)
        begin
          pdata_q[p*8 +: 8] <= msr_pkg::RST_ZERO;
          pdir_q[p*8 +: 8] <= msr_pkg::RST_DIR;
        end
        else if (ce_in)
        begin
          pdata_q[p*8 +: 8] <= oper_q[p+5];
          pdir_q[p*8 +: 8] <= ctrl_q[p+5];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      mode_q <= msr_pkg::RST_MODE;
      flags_q <= msr_pkg::RST_ZERO;
      mask_q <= msr_pkg::RST_ZERO;
      ecmd_q <= msr_pkg::RST_EEPROM;
    end
    else if (ce_in)
    begin
      mode_q <= ctrl_q[10];
      flags_q <= oper_q[15];
      mask_q <= ctrl_q[15];
      ecmd_q <= oper_q[10];
    end
  end

  assign rdata_out = rdata_q;
  assign bit_out = bit_q;
  assign port_data_out = pdata_q;
  assign port_dir_out = pdir_q;
  assign mode_out = mode_q;
  assign irq_flags_out = flags_q;
  assign irq_mask_out = mask_q;
  assign eeprom_cmd_out = ecmd_q;
  assign eeprom_start_out = eeprom_start_q;
  assign prescale_out = prescale_q;

  // ****************************************
  // checks
  // ****************************************
  property p_indirect_read;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && rd_in && !ctrl_space_in && addr_in == 6'h00 && oper_q[4][5:0] == 6'h05)
    |=> rdata_out == $past(oper_q[5]);
  endproperty
  a_indirect_read: assert property (p_indirect_read) else $error("indirect read wrong");

  property p_extra_low;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && rd_in && is_extra && eff_addr == 6'h0B)
    |=> rdata_out == {6'h00, $past(adc_result_in[1:0])};
  endproperty
  a_extra_low: assert property (p_extra_low) else $error("adc low read wrong");

  property p_ctrl_sep;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && wr_in && ctrl_space_in && addr_in == 6'h06)
    |=> ##1 port_dir_out[15:8] == $past(wdata_in, 2) && $stable(oper_q[6]);
  endproperty
  a_ctrl_sep: assert property (p_ctrl_sep) else $error("control write leaked");

  property p_ee_start;
    @(posedge clk_sys_in) disable iff (rst_in)
    eeprom_start_out |-> $past(wr_in) && !$past(ctrl_space_in);
  endproperty
  a_ee_start: assert property (p_ee_start) else $error("spurious eeprom start");

  property p_flag_set;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && hw_irq_in[0]) |=> ##1 irq_flags_out[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("irq flag lost");

  property p_bit_set;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ce_in && bit_set_in && !bit_clr_in && !wr_in && acc == msr_pkg::MSR_OPER &&
     eff_addr == 6'h08)
    |=> oper_q[8] == ($past(oper_q[8]) | (8'h01 << $past(bit_sel_in)));
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set disturbed others");

  c_extra: cover property (@(posedge clk_sys_in) disable iff (rst_in) ce_in && rd_in && is_extra);
  c_bitset: cover property (@(posedge clk_sys_in) disable iff (rst_in) ce_in && bit_set_in);
  c_indirect: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && wr_in && !ctrl_space_in && addr_in == 6'h00);
endmodule // msr_register_map

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // stimulus and observation signals
  // ****************************************
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic [5:0] addr_in = 6'h00;
  logic ctrl_space_in = 1'b0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] wdata_in = 8'h00;
  logic bit_set_in = 1'b0;
  logic bit_clr_in = 1'b0;
  logic bit_test_in = 1'b0;
  logic [2:0] bit_sel_in = 3'h0;
  logic prescale_wr_in = 1'b0;
  logic [9:0] adc_result_in = 10'h000;
  logic eeprom_done_in = 1'b0;
  logic [7:0] hw_irq_in = 8'h00;
  logic [7:0] rdata_out, mode_out, irq_flags_out, irq_mask_out, eeprom_cmd_out, prescale_out;
  logic bit_out, eeprom_start_out, taken, is_bit;
  logic [39:0] port_data_out, port_dir_out;
  logic [7:0] exp_q[$];
  logic [7:0] d, v[5];
  int n_mismatch = 0;
  int compares = 0;
  int seed = 56;
  int cnt;

  msr_register_map msr_register_map_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
    .addr_in(addr_in), .ctrl_space_in(ctrl_space_in), .wr_in(wr_in), .rd_in(rd_in),
    .wdata_in(wdata_in), .bit_set_in(bit_set_in), .bit_clr_in(bit_clr_in),
    .bit_test_in(bit_test_in), .bit_sel_in(bit_sel_in), .prescale_wr_in(prescale_wr_in),
    .adc_result_in(adc_result_in), .eeprom_done_in(eeprom_done_in), .hw_irq_in(hw_irq_in),
    .port_pins_in(40'h00_0000_0000), .rdata_out(rdata_out), .bit_out(bit_out),
    .port_data_out(port_data_out), .port_dir_out(port_dir_out), .mode_out(mode_out),
    .irq_flags_out(irq_flags_out), .irq_mask_out(irq_mask_out),
    .eeprom_cmd_out(eeprom_cmd_out), .eeprom_start_out(eeprom_start_out),
    .prescale_out(prescale_out));

  initial
  begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // kinds: 0 write, 1 read, 2 bit set, 3 bit clear, 4 bit test, 5 prescaler write
  // each step sets every strobe once, high for its kind and low otherwise, so no strobe changes twice per step
  task automatic op(input int k, input logic c, input logic [5:0] a, input logic [7:0] dd,
    input logic [2:0] b);
    ctrl_space_in = c;
    addr_in = a;
    wdata_in = dd;
    bit_sel_in = b;
    wr_in = (k == 0);
    rd_in = (k == 1);
    bit_set_in = (k == 2);
    bit_clr_in = (k == 3);
    bit_test_in = (k == 4);
    prescale_wr_in = (k == 5);
    @(posedge clk_sys_in);
    #1;
  endtask

  task automatic rd(input logic c, input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    op(1, c, a, 8'h00, 3'h0);
  endtask

  task automatic tst(input logic [5:0] a, input logic [2:0] b, input logic e);
    exp_q.push_back({7'h00, e});
    op(4, 1'b0, a, 8'h00, b);
  endtask

  task automatic settle();
    {wr_in, rd_in, bit_set_in, bit_clr_in, bit_test_in, prescale_wr_in} = 6'h00;
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask

  // ****************************************
  // result monitor: oldest note against each answer
  // ****************************************
  always @(posedge clk_sys_in)
  begin
    taken = ce_in && !rst_in && (rd_in || bit_test_in);
    is_bit = bit_test_in;
    #2;
    if (taken)
    begin
      if (exp_q.size() == 0)
        check(40'h1, 40'h0);
      else if (is_bit)
        check({7'h00, bit_out}, exp_q.pop_front());
      else
        check(rdata_out, exp_q.pop_front());
    end
  end

  initial
  begin
    #500000;
    n_mismatch++;
    print_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    check(port_dir_out, 40'hFF_FFFF_FFFF);
    check({mode_out, irq_mask_out, irq_flags_out}, 24'hC0_0000);
    check({prescale_out, eeprom_cmd_out, port_data_out[7:0]}, 24'h3F_FF00);
    // same offsets, two spaces, back to back
    for (int i = 0; i < 5; i++)
    begin
      v[i] = 8'($random(seed));
      op(0, 1'b1, 6'(5 + i), v[i], 3'h0);
    end
    d = 8'($random(seed));
    op(0, 1'b0, 6'h05, d, 3'h0);
    rd(1'b0, 6'h05, d);
    rd(1'b1, 6'h05, v[0]);
    rd(1'b1, 6'h06, v[1]);
    settle();
    for (int i = 0; i < 5; i++)
      check(port_dir_out[8 * i +: 8], v[i]);
    check(port_data_out[7:0], d);
    // indirect access through two banks and onto a special register
    op(0, 1'b0, 6'h04, 8'h10, 3'h0);
    op(0, 1'b0, 6'h00, 8'h3C, 3'h0);
    op(0, 1'b0, 6'h04, 8'h50, 3'h0);
    op(0, 1'b0, 6'h00, 8'hC3, 3'h0);
    rd(1'b0, 6'h00, 8'hC3);
    op(0, 1'b0, 6'h04, 8'h10, 3'h0);
    rd(1'b0, 6'h00, 8'h3C);
    rd(1'b0, 6'h10, 8'h3C);
    op(0, 1'b0, 6'h04, 8'h06, 3'h0);
    op(0, 1'b0, 6'h00, 8'h96, 3'h0);
    rd(1'b0, 6'h06, 8'h96);
    settle();
    check(port_data_out[15:8], 8'h96);
    // every bit of a port register on its own
    for (int b = 0; b < 8; b++)
    begin
      d = 8'($random(seed));
      op(0, 1'b0, 6'h08, d, 3'h0);
      op(2, 1'b0, 6'h08, 8'h00, 3'(b));
      tst(6'h08, 3'(b), 1'b1);
      op(3, 1'b0, 6'h08, 8'h00, 3'(b));
      tst(6'h08, 3'(b), 1'b0);
      d[b] = 1'b0;
      rd(1'b0, 6'h08, d);
    end
    settle();
    check(port_data_out[31:24], d);
    ce_in = 1'b0;
    op(0, 1'b0, 6'h08, ~d, 3'h0);
    ce_in = 1'b1;
    rd(1'b0, 6'h08, d);
    // extra bank swap and conversion result split
    adc_result_in = 10'($random(seed));
    op(0, 1'b1, 6'h0A, 8'hC8, 3'h0);
    rd(1'b0, 6'h0B, {6'h00, adc_result_in[1:0]});
    rd(1'b0, 6'h0C, adc_result_in[9:2]);
    op(0, 1'b0, 6'h0D, 8'h02, 3'h0);
    rd(1'b0, 6'h0D, 8'h02);
    op(0, 1'b1, 6'h0A, 8'hC0, 3'h0);
    rd(1'b0, 6'h0D, 8'h00);
    settle();
    check(mode_out, 8'hC0);
    // interrupt flags and mask, prescaler
    hw_irq_in = 8'h09;
    op(0, 1'b1, 6'h0F, 8'hA5, 3'h0);
    hw_irq_in = 8'h00;
    rd(1'b0, 6'h0F, 8'h09);
    op(5, 1'b0, 6'h00, 8'h5A, 3'h0);
    settle();
    check({irq_flags_out, irq_mask_out, prescale_out}, 24'h09_A55A);
    // one eeprom command, then only its completion (no second command issued)
    op(0, 1'b0, 6'h0A, 8'h01, 3'h0);
    {wr_in, rd_in, bit_set_in, bit_clr_in, bit_test_in, prescale_wr_in} = 6'h00;
    cnt = (eeprom_start_out === 1'b1);
    repeat (3)
    begin
      @(posedge clk_sys_in);
      #1;
      cnt += (eeprom_start_out === 1'b1);
    end
    check(cnt, 1);
    check(eeprom_cmd_out[1:0], 2'h1);
    eeprom_done_in = 1'b1;
    @(posedge clk_sys_in);
    #1;
    eeprom_done_in = 1'b0;
    tst(6'h0A, 3'h2, 1'b1);
    settle();
    // reset again mid-run: mode, flags, eeprom, prescaler and port registers must fall back to reset values (banked general registers have no reset)
    rst_in = 1'b1;
    @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    check({mode_out, irq_flags_out, eeprom_cmd_out, prescale_out}, 32'hC0_00FF_3F);
    check(port_data_out, 40'h00_0000_0000);
    rd(1'b1, 6'h05, 8'hFF);
    settle();
    check(exp_q.size(), 0);
    print_verdict();
  end
endmodule // testbench
